//--- rtl/led_seq_regs.vh
`ifndef LED_SEQ_REGS_VH
`define LED_SEQ_REGS_VH

// Register indices; byte address is four times the index
`define IDX_BEHAV_HIGH 10'h083
`define IDX_PULSE_ONE 10'h084
`define IDX_CHAN_CTRL 10'h0A0
`define IDX_AUX_PERIOD 10'h0A1
`define IDX_STATUS 10'h0A2

// Reset values
`define RST_BEHAV_HIGH 8'h00
`define RST_PULSE_ONE 8'h20
`define RST_CHAN_CTRL 15'h4000
`define RST_PULSE_TWO_PER 7'h14
`define RST_BREATHE_PER 7'h5D

// Behaviour and pulse 1 register fields
`define F_CH9_LO 1
`define F_CH10_LO 3
`define F_AWAKE_LO 5
`define F_SLEEP_LO 7
`define F_START_REL 7
`define F_P1_PER_HI 6

// Channel control fields
`define F_DRIVE_LO 0
`define F_POL_LO 3
`define F_LINK_LO 6
`define F_PWR_IND 9
`define F_SLEEP 10
`define F_DEEP 11
`define F_P1_CNT_LO 12

// Auxiliary period fields
`define F_P2_PER_LO 0
`define F_BR_PER_LO 8

// Behaviour codes
`define CODE_DIRECT 2'b00
`define CODE_PULSE_ONE 2'b01
`define CODE_PULSE_TWO 2'b10
`define CODE_BREATHE 2'b11

// Timing: one period count is 32 steps of one millisecond
`define PERIOD_UNIT_MS 32
`define STEP_US 1000
`define CLK_MHZ 50
`define STEP_CYCLES (`STEP_US * `CLK_MHZ)
`define STEPS_PER_PULSE 32

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- rtl/period_tick.v
`timescale 1ns/1ps
module period_tick #(
  parameter [31:0] CYCLES = 32'd50000
)(
  input wire i_core_clk,
  input wire i_sys_rst,
  output reg o_tick
);
  reg [31:0] cnt_reg;

  // One-cycle pulse every CYCLES clocks
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_reg <= 32'h00000000;
      o_tick <= 1'b0;
    end
    else if (cnt_reg == CYCLES - 32'd1)
    begin
      cnt_reg <= 32'h00000000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'd1;
      o_tick <= 1'b0;
    end
  end
endmodule

//--- rtl/led_channel_engine.v
`timescale 1ns/1ps
`include "led_seq_regs.vh"
module led_channel_engine (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire [1:0] i_code,
  input wire i_trigger,
  input wire i_start_on_release,
  input wire [2:0] i_count,
  input wire [6:0] i_period,
  input wire i_step_tick,
  input wire [3:0] i_pwm_cnt,
  input wire i_polarity,
  output reg o_led,
  output reg o_active
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_DIRECT = 4'b0010;
  localparam ST_COUNTED = 4'b0100;
  localparam ST_REPEAT = 4'b1000;

  reg [3:0] state_reg;
  reg trig_prev_reg;
  reg [1:0] code_reg;
  reg [6:0] step_cnt_reg;
  reg [4:0] pos_reg;
  reg [3:0] left_reg;
  wire rise;
  wire fall;
  wire [6:0] period;
  wire step_wrap;
  wire pulse_end;
  wire running;
  wire [3:0] level;
  wire lit;
  wire p1_start;

  assign rise = i_trigger & ~trig_prev_reg;
  assign fall = ~i_trigger & trig_prev_reg;
  assign period = (i_period == 7'h00) ? 7'h01 : i_period;
  assign step_wrap = i_step_tick && (step_cnt_reg == period - 7'h01);
  assign pulse_end = step_wrap && (pos_reg == 5'h1F);
  assign running = (state_reg == ST_COUNTED) || (state_reg == ST_REPEAT);
  // Rising half then falling half of each pulse
  assign level = pos_reg[4] ? ~pos_reg[3:0] : pos_reg[3:0];
  assign p1_start = i_start_on_release ? fall : rise;
  // Direct is full on with the fastest PWM
  assign lit = (state_reg == ST_DIRECT) ? 1'b1 :
    (running && (level == 4'hF || i_pwm_cnt < level));

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= ST_IDLE;
      trig_prev_reg <= 1'b0;
      code_reg <= `CODE_DIRECT;
      step_cnt_reg <= 7'h00;
      pos_reg <= 5'h00;
      left_reg <= 4'h0;
      o_led <= 1'b0;
      o_active <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= i_trigger;
      o_led <= i_polarity ? lit : ~lit;
      o_active <= (state_reg != ST_IDLE);
      if (running && i_step_tick)
      begin
        if (step_wrap)
        begin
          step_cnt_reg <= 7'h00;
          pos_reg <= pos_reg + 5'h01;
        end
        else
          step_cnt_reg <= step_cnt_reg + 7'h01;
      end
      case (state_reg)
        ST_IDLE:
        begin
          step_cnt_reg <= 7'h00;
          pos_reg <= 5'h00;
          code_reg <= i_code;
          left_reg <= {1'b0, i_count} + 4'h1;
          if (i_code == `CODE_DIRECT && rise)
            state_reg <= ST_DIRECT;
          else if (i_code == `CODE_PULSE_ONE && p1_start)
            state_reg <= ST_COUNTED;
          else if (i_code[1] && rise)
            state_reg <= ST_REPEAT;
        end
        ST_DIRECT:
        begin
          if (fall)
            state_reg <= ST_IDLE;
        end
        ST_COUNTED:
        begin
          // Pulse 1 ignores triggers until done
          if (pulse_end)
          begin
            if (left_reg == 4'h1)
              state_reg <= ST_IDLE;
            else
              left_reg <= left_reg - 4'h1;
          end
        end
        ST_REPEAT:
        begin
          if (fall)
          begin
            if (code_reg == `CODE_PULSE_TWO)
            begin
              state_reg <= ST_COUNTED;
              left_reg <= {1'b0, i_count} + 4'h1;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- rtl/led_behavior_sequencer.v
// Contract
// - Asleep power channel uses bits 7:6
// - Awake power channel uses bits 5:4
// - Bits 3:2 channel ten, 1:0 nine
// - Direct follows touch/set and release/clear
// - Pulse 1 emits counted pulses, no stop
// - Bit 7 selects release as start
// - Pulse 2 repeats, then counted tail
// - Breathe ramps min to max continuously
// - Each ramp takes half the period
// - Direct uses maximum PWM frequency
// - Period field counts 32 ms units
// - Zero period acts as one
// - Pulse count comes from register field
// - Unlinked drive bit acts as touch
// - Polarity sets idle level of output
`timescale 1ns/1ps
`include "led_seq_regs.vh"
module led_behavior_sequencer #(
  parameter [31:0] STEP_CYCLES = `STEP_CYCLES
)(
  input wire I_CORE_CLK,
  input wire I_SYS_RST,
  input wire [2:0] I_TOUCH,
  input wire [11:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  input wire [11:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  output wire [2:0] O_LED
);
  reg [7:0] behav_high_reg;
  reg [7:0] pulse_one_reg;
  reg [14:0] chan_ctrl_reg;
  reg [6:0] pulse_two_per_reg;
  reg [6:0] breathe_per_reg;
  reg aw_full_reg;
  reg [9:0] aw_idx_reg;
  reg w_full_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [3:0] pwm_cnt_reg;
  reg [31:0] rdata_next;
  reg rhit_next;
  wire step_tick;
  wire do_write;
  wire [9:0] ar_idx;
  wire [2:0] active;
  wire asleep;
  wire [5:0] codes;

  period_tick #(
    .CYCLES(STEP_CYCLES)
  ) u_tick (
    .i_core_clk(I_CORE_CLK),
    .i_sys_rst(I_SYS_RST),
    .o_tick(step_tick)
  );

  assign asleep = chan_ctrl_reg[`F_SLEEP] | chan_ctrl_reg[`F_DEEP];
  assign codes[1:0] = behav_high_reg[`F_CH9_LO -: 2];
  assign codes[3:2] = behav_high_reg[`F_CH10_LO -: 2];
  assign codes[5:4] = (chan_ctrl_reg[`F_PWR_IND] && asleep) ?
    behav_high_reg[`F_SLEEP_LO -: 2] :
    behav_high_reg[`F_AWAKE_LO -: 2];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen_chan
      wire [1:0] code;
      wire trig;
      wire [6:0] per;
      assign code = codes[2*g+1:2*g];
      assign trig = chan_ctrl_reg[`F_LINK_LO+g] ? I_TOUCH[g] :
        chan_ctrl_reg[`F_DRIVE_LO+g];
      assign per = (code == `CODE_PULSE_ONE) ?
        pulse_one_reg[`F_P1_PER_HI:0] :
        (code == `CODE_PULSE_TWO) ? pulse_two_per_reg :
        breathe_per_reg;
      led_channel_engine u_engine (
        .i_core_clk(I_CORE_CLK),
        .i_sys_rst(I_SYS_RST),
        .i_code(code),
        .i_trigger(trig),
        .i_start_on_release(pulse_one_reg[`F_START_REL]),
        .i_count(chan_ctrl_reg[`F_P1_CNT_LO+2:`F_P1_CNT_LO]),
        .i_period(per),
        .i_step_tick(step_tick),
        .i_pwm_cnt(pwm_cnt_reg),
        .i_polarity(chan_ctrl_reg[`F_POL_LO+g]),
        .o_led(O_LED[g]),
        .o_active(active[g])
      );
    end
  endgenerate

  // Free-running PWM counter at full clock rate
  always @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      pwm_cnt_reg <= 4'h0;
    else
      pwm_cnt_reg <= pwm_cnt_reg + 4'h1;
  end

  assign do_write = aw_full_reg & w_full_reg & ~O_BVALID;
  assign ar_idx = I_ARADDR[11:2];

  // Write channel: address and data taken in either order
  always @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `RESP_OKAY;
      aw_full_reg <= 1'b0;
      aw_idx_reg <= 10'h000;
      w_full_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      behav_high_reg <= `RST_BEHAV_HIGH;
      pulse_one_reg <= `RST_PULSE_ONE;
      chan_ctrl_reg <= `RST_CHAN_CTRL;
      pulse_two_per_reg <= `RST_PULSE_TWO_PER;
      breathe_per_reg <= `RST_BREATHE_PER;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= I_AWADDR[11:2];
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
        O_BVALID <= 1'b1;
        O_BRESP <= `RESP_OKAY;
        case (aw_idx_reg)
          `IDX_BEHAV_HIGH:
          begin
            if (wstrb_reg[0])
              behav_high_reg <= wdata_reg[7:0];
          end
          `IDX_PULSE_ONE:
          begin
            if (wstrb_reg[0])
              pulse_one_reg <= wdata_reg[7:0];
          end
          `IDX_CHAN_CTRL:
          begin
            if (wstrb_reg[0])
              chan_ctrl_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1])
              chan_ctrl_reg[14:8] <= wdata_reg[14:8];
          end
          `IDX_AUX_PERIOD:
          begin
            if (wstrb_reg[0])
              pulse_two_per_reg <= wdata_reg[6:0];
            if (wstrb_reg[1])
              breathe_per_reg <= wdata_reg[14:8];
          end
          `IDX_STATUS:
            O_BRESP <= `RESP_OKAY;
          default:
            O_BRESP <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // Read mux
  always @*
  begin
    rdata_next = 32'h00000000;
    rhit_next = 1'b1;
    case (ar_idx)
      `IDX_BEHAV_HIGH:
        rdata_next[7:0] = behav_high_reg;
      `IDX_PULSE_ONE:
        rdata_next[7:0] = pulse_one_reg;
      `IDX_CHAN_CTRL:
        rdata_next[14:0] = chan_ctrl_reg;
      `IDX_AUX_PERIOD:
        rdata_next[14:0] = {breathe_per_reg, 1'b0, pulse_two_per_reg};
      `IDX_STATUS:
        rdata_next[5:0] = {active, O_LED};
      default:
        rhit_next = 1'b0;
    endcase
  end

  always @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= rdata_next;
      O_RRESP <= rhit_next ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (O_RVALID && I_RREADY)
    begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end
endmodule

//--- tb/led_seq_props.sv
`timescale 1ns/1ps
module led_seq_props (
  input wire I_CORE_CLK,
  input wire I_SYS_RST,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire [1:0] O_BRESP,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire [1:0] O_RRESP,
  input wire O_RVALID,
  input wire I_RREADY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence both_taken;
    !O_BVALID && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence read_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  a_write_answer: assert property (both_taken |-> ##2 O_BVALID)
    else $error("write response late");
  a_read_answer: assert property (read_taken |=> O_RVALID && !O_ARREADY)
    else $error("read response late");
  a_bvalid_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rvalid_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
    else $error("read data changed");
  a_read_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read valid stuck");
  a_write_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write valid stuck");
  a_slverr_zero: assert property (O_RVALID && O_RRESP == 2'b10 |->
    O_RDATA == 32'h0)
    else $error("error read carries data");
  a_resp_code: assert property (O_BVALID |->
    O_BRESP == 2'b00 || O_BRESP == 2'b10)
    else $error("bad write response");
endmodule
bind led_behavior_sequencer led_seq_props u_props (
  .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
  .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY)
);

//--- tb/led_load.sv
`timescale 1ns/1ps
module led_load (
  input wire i_clk,
  input wire [2:0] i_led,
  input wire [2:0] i_pol,
  input wire i_clear,
  output reg [2:0][7:0] o_lit
);
  integer c;
  always @(posedge i_clk)
  begin
    for (c = 0; c < 3; c = c + 1)
    begin
      // Lamp glows while pin sits at the active level
      if (i_clear)
        o_lit[c] <= 8'h00;
      else if (i_led[c] === i_pol[c] && o_lit[c] != 8'hFF)
        o_lit[c] <= o_lit[c] + 8'h01;
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam STEP = 4;
  reg clk = 0, rst = 1, lclr = 1;
  reg [2:0] touch = 0;
  reg [11:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, rd_v;
  reg [31:0] rnd;
  reg [3:0] wstrb = 4'hF;
  reg [1:0] rd_r;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] led;
  wire [2:0][7:0] lit;
  integer n_errors = 0, check_count = 0, cyc = 0, i, t0, per, cnt, ex;
  integer seed = 32'h3f39d145;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  led_behavior_sequencer #(.STEP_CYCLES(STEP)) dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_TOUCH(touch), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_LED(led)
  );
  led_load load (.i_clk(clk), .i_led(led), .i_pol(3'b000),
    .i_clear(lclr), .o_lit(lit));
  task conclude;
  begin
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    integer k;
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k = k + 1)
    begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    if (k == 64)
      chk("write timeout", 0, 1);
    chk("bresp", er, bresp);
  end
  endtask
  task rd(input [11:0] a);
    integer k;
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k = k + 1)
    begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    rd_v = rdata;
    rd_r = rresp;
    if (k == 64)
      chk("read timeout", 0, 1);
  end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
  begin
    rd(a);
    chk("rresp", 0, rd_r);
    chk("rdata", e, rd_v);
  end
  endtask
  task waitbit(input integer b, input v);
    integer k;
  begin
    for (k = 0; k < 600 && rd_v[b] !== v; k = k + 1)
      rd(12'h288);
    if (k == 600)
    begin
      chk("wait timeout", 0, 1);
      conclude;
    end
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(12'h20C, 0);
    rdc(12'h210, 32'h20);
    rdc(12'h280, 32'h4000);
    rdc(12'h284, 32'h5D14);
    rd(12'h3FC);
    chk("unmapped rresp", 2'b10, rd_r);
    wr(12'h3FC, 1, 2'b10);
    for (i = 0; i < 4; i = i + 1)
    begin
      rnd = $random(seed);
      wr(12'h20C, rnd, 0);
      rdc(12'h20C, rnd & 32'hFF);
      wr(12'h210, ~rnd, 0);
      rdc(12'h210, ~rnd & 32'hFF);
    end
    $display("registers done");
    wr(12'h20C, 32'h04, 0);
    wr(12'h280, 0, 0);
    repeat (5) @(posedge clk);
    chk("idle pol0", 1, led[0]);
    wr(12'h280, 1, 0);
    repeat (5) @(posedge clk);
    chk("direct on", 0, led[0]);
    wr(12'h280, 32'h8, 0);
    repeat (5) @(posedge clk);
    chk("idle pol1", 0, led[0]);
    wr(12'h280, 32'h40, 0);
    touch <= 3'b001;
    repeat (5) @(posedge clk);
    chk("touch on", 0, led[0]);
    touch <= 3'b000;
    repeat (5) @(posedge clk);
    chk("release off", 1, led[0]);
    $display("direct done");
    for (i = 0; i < 5; i = i + 1)
    begin
      per = (i == 0) ? 0 : {$random(seed)} % 4;
      cnt = (i == 0) ? 0 : {$random(seed)} % 3;
      ex = 32 * STEP * ((per == 0) ? 1 : per) * (cnt + 1);
      wr(12'h210, per, 0);
      wr(12'h280, (cnt << 12) | 2, 0);
      t0 = cyc;
      rd_v = 1 << 4;
      waitbit(4, 0);
      chk("pulse time", 1, (cyc - t0 >= ex - 4) && (cyc - t0 <= ex + 24));
      wr(12'h280, cnt << 12, 0);
    end
    wr(12'h210, 32'h81, 0);
    wr(12'h280, 2, 0);
    repeat (8) @(posedge clk);
    rd(12'h288);
    chk("no start on set", 0, rd_v[4]);
    wr(12'h280, 0, 0);
    rd(12'h288);
    chk("start on clear", 1, rd_v[4]);
    waitbit(4, 0);
    $display("pulse done");
    wstrb <= 4'h1;
    wr(12'h284, 32'hFF01, 0);
    wstrb <= 4'hF;
    rdc(12'h284, 32'h5D01);
    wr(12'h20C, 32'h08, 0);
    wr(12'h280, 2, 0);
    repeat (300) @(posedge clk);
    rd(12'h288);
    chk("pulse two repeats", 1, rd_v[4]);
    wr(12'h280, 0, 0);
    t0 = cyc;
    waitbit(4, 0);
    chk("pulse two tail", 1, cyc - t0 <= 32 * STEP + 24);
    $display("pulse two done");
    wr(12'h20C, 32'hC4, 0);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(12'h280, 32'h204 | ((i == 0) ? 0 : (32'h200 << i)), 0);
      repeat (8) @(posedge clk);
      lclr <= 1'b1;
      @(posedge clk);
      lclr <= 1'b0;
      repeat (32) @(posedge clk);
      chk("last channel full", i == 0, lit[2] >= 30);
      rd(12'h288);
      chk("last channel active", 1, rd_v[5]);
      wr(12'h280, 32'h200, 0);
      rd(12'h288);
      chk("last channel stop", 0, rd_v[5]);
    end
    $display("last channel done");
    conclude;
  end
endmodule
